// file: rtl/uis_defines.vh
// Register map, field codes, reset values and timing constants of the UART interrupt and status block.
//
// Contract
// [RQ1] In FIFO mode, receive interrupt follows fill level against the receive trigger level.
// [RQ2] Data-ready flag is set on first character pushed and clears when empty.
// [RQ3] FIFOs on with enable bits 0-3 clear gives polled mode through line status.
// [RQ4] Line status shows overrun, head-byte errors, holding empty, all empty, any error.
// [RQ5] Receive interrupt: holding register full without FIFO, trigger level with FIFO.
// [RQ6] Transmit interrupt on holding empty or below trigger; also when enabled while empty.
// [RQ7] Overrun interrupts at once; parity, framing, break interrupt when read out.
// [RQ8] Enhanced enable bit gates upper enable, status, trigger and modem control bits.
// [RQ9] Flow-change interrupt on rising clear-to-send or request-to-send during auto flow.
// [RQ10] Receive time-out after four characters plus twelve bits; cleared by data read.
// [RQ11] Modem status interrupt from any delta bit; cleared by modem status read.
// [RQ12] Line status read clears its interrupt; global error stays until errors read out.
// [RQ13] Receive-ready interrupt clears only when reads bring level below trigger.
// [RQ14] Transmit interrupt clears on status read or transmit holding write.
// [RQ15] Stop-character and special-character interrupts clear on status read or next event.
// [RQ16] Flow-change clears on modem status read; wake-up clears on status read.
// [RQ17] Status bits 5-0 encode the seven sources by priority; 000001 means none.
// [RQ18] Status read returns only the top pending source; others stay queued.
// [RQ19] Status bit 0 is 0 when pending, 1 when idle or woken; the code sets it only when idle, as wake_r never reaches the status.
// [RQ20] Status bit 4 holds after stop match until resume; bit 5 shows flow change.
// [RQ21] Status bits 7 and 6 mirror the FIFO enable.
// [RQ22] Divisor latches are reached only while line control bit 7 is set.
// [RQ23] Modem control bit 3 enables the interrupt output, else it floats.
// [RQ24] Interrupt output is active exactly when some enabled source is pending.
// [RQ25] Address decode uses line control bit 7 and the enhanced value to pick banks.
`ifndef UIS_DEFINES_VH
`define UIS_DEFINES_VH
`define UIS_OFS_DATA 3'h0
`define UIS_OFS_IER 3'h1
`define UIS_OFS_ISR 3'h2
`define UIS_OFS_LCR 3'h3
`define UIS_OFS_MCR 3'h4
`define UIS_OFS_LSR 3'h5
`define UIS_OFS_MSR 3'h6
`define UIS_OFS_SPR 3'h7
`define UIS_LCR_ENH 8'hBF
`define UIS_LCR_DLAB 7
`define UIS_EFR_ENH 4
`define UIS_RST_BYTE 8'h00
`define UIS_SYNC_RST 18'h3800F
`define UIS_SRC_LSR 6'h06
`define UIS_SRC_TMO 6'h0C
`define UIS_SRC_RXR 6'h04
`define UIS_SRC_TXR 6'h02
`define UIS_SRC_MSR 6'h00
`define UIS_SRC_XCH 6'h10
`define UIS_SRC_FLC 6'h20
`define UIS_SRC_NONE 6'h01
`define UIS_TRIG_0 5'h01
`define UIS_TRIG_1 5'h04
`define UIS_TRIG_2 5'h08
`define UIS_TRIG_3 5'h0E
`define UIS_TMO_CHARS 4
`define UIS_TMO_BITS 12
`define UIS_CHAR_BASE 4'h7
`endif

// file: rtl/uis_intr_status.v
// Host register file, interrupt ranking and status reporting of a 16-byte FIFO UART.
`include "uis_defines.vh"

module uis_intr_status #(
    parameter [7:0] REV_CODE = 8'h2A,  // Arbitrary value.
    parameter [7:0] DEV_ID = 8'h5C     // Arbitrary value.
) (
    input wire clock_i,
    input wire reset_i,
    input wire cs_n_i,
    input wire rd_n_i,
    input wire wr_n_i,
    input wire [2:0] addr_i,
    input wire [7:0] data_i,
    output reg [7:0] data_o,
    output reg data_oe_o,
    output reg irq_o,
    output reg irq_oe_o,
    input wire cts_n_i,
    input wire dsr_n_i,
    input wire cd_n_i,
    input wire ri_n_i,
    input wire rts_n_i,
    input wire [7:0] rx_data_i,
    input wire [4:0] rx_level_i,
    input wire rx_push_i,
    input wire rx_push_err_i,
    input wire [2:0] rx_head_err_i,
    input wire overrun_i,
    input wire thr_empty_i,
    input wire tx_empty_i,
    input wire [4:0] tx_level_i,
    input wire bit_tick_i,
    input wire xoff_det_i,
    input wire xon_det_i,
    input wire special_det_i,
    input wire wake_i,
    output reg rx_pop_o,
    output reg tx_push_o,
    output reg [7:0] tx_data_o,
    output reg [15:0] divisor_o,
    output reg [7:0] line_control_o,
    output reg [7:0] modem_control_o,
    output reg [7:0] enhanced_o,
    output reg fifo_enable_o,
    output reg rx_fifo_reset_o,
    output reg tx_fifo_reset_o,
    output reg [1:0] rx_trigger_o,
    output reg [1:0] tx_trigger_o,
    output reg [15:0] resume_chars_o,
    output reg [15:0] stop_chars_o,
    output reg sleep_enable_o
);

    function [4:0] trig_lvl;
        input [1:0] sel;
        begin
            case (sel)
                2'h0: trig_lvl = `UIS_TRIG_0;
                2'h1: trig_lvl = `UIS_TRIG_1;
                2'h2: trig_lvl = `UIS_TRIG_2;
                default: trig_lvl = `UIS_TRIG_3;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and host strobe edges.

    reg [17:0] sync1_r;
    reg [17:0] sync2_r;
    reg rd_prev_r;
    reg wr_prev_r;
    reg [2:0] wa_r;
    reg [7:0] wd_r;

    wire cs_act = ~sync2_r[17];
    wire rd_act = cs_act & ~sync2_r[16];
    wire wr_act = cs_act & ~sync2_r[15];
    wire [2:0] ra = sync2_r[14:12];
    wire rd_go = rd_act & ~rd_prev_r;
    // Writes commit on the trailing strobe edge so late data still lands.
    wire wr_done = ~wr_act & wr_prev_r;

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_r <= `UIS_SYNC_RST;
            sync2_r <= `UIS_SYNC_RST;
            rd_prev_r <= 1'b0;
            wr_prev_r <= 1'b0;
            wa_r <= 3'h0;
            wd_r <= `UIS_RST_BYTE;
        end else begin
            sync1_r <= {cs_n_i, rd_n_i, wr_n_i, addr_i, data_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
            sync2_r <= sync1_r;
            rd_prev_r <= rd_act;
            wr_prev_r <= wr_act;
            if (wr_act) begin
                wa_r <= ra;
                wd_r <= sync2_r[11:4];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bank selection.

    reg [7:0] ier_r;
    reg [7:0] lcr_r;
    reg [7:0] mcr_r;
    reg [7:0] efr_r;
    reg [7:0] spr_r;
    reg [7:0] dll_r;
    reg [7:0] dlm_r;

    wire enh = efr_r[`UIS_EFR_ENH];
    wire bank_bf = (lcr_r == `UIS_LCR_ENH);  // [RQ25]
    wire dlab = lcr_r[`UIS_LCR_DLAB];        // [RQ22]
    wire div_zero = (dll_r == 8'h00) && (dlm_r == 8'h00);
    wire [7:0] ier_eff = {ier_r[7:4] & {4{enh}}, ier_r[3:0]};  // [RQ8]
    wire [7:0] mcr_eff = {mcr_r[7:5] & {3{enh}}, mcr_r[4:3], mcr_r[2] & enh, mcr_r[1:0]};  // [RQ8]

    wire rd_rhr = rd_go && (ra == `UIS_OFS_DATA) && !dlab;
    wire rd_isr = rd_go && (ra == `UIS_OFS_ISR) && !bank_bf;
    wire rd_lsr = rd_go && (ra == `UIS_OFS_LSR) && !bank_bf;
    wire rd_msr = rd_go && (ra == `UIS_OFS_MSR) && !bank_bf;
    wire wr_thr = wr_done && (wa_r == `UIS_OFS_DATA) && !dlab;

    ////////////////////////////////////////////////////////////////////////////
    // Source conditions.

    reg lsr_pend_r;
    reg overrun_r;
    reg [2:0] lsr_err_r;
    reg head_new_r;
    reg [4:0] err_cnt_r;
    reg [6:0] tmo_cnt_r;
    reg timeout_r;
    reg transmit_ready_irq_r;
    reg tx_cond_prev_r;
    reg ier1_prev_r;
    reg [3:0] msr_prev_r;
    reg [3:0] msr_delta_r;
    reg rts_prev_r;
    reg flc_pend_r;
    reg xoff_pend_r;
    reg xoff_hold_r;
    reg spec_pend_r;
    reg wake_r;

    wire rx_any = (rx_level_i != 5'h00);
    wire [4:0] rx_trig = trig_lvl(rx_trigger_o);
    wire [4:0] tx_trig = trig_lvl(tx_trigger_o);
    wire rx_cond = fifo_enable_o ? (rx_level_i >= rx_trig) : rx_any;  // [RQ1] [RQ5] [RQ13]
    wire tx_cond = fifo_enable_o ? (tx_level_i < tx_trig) : thr_empty_i;
    wire loop = mcr_r[4];
    // Loopback feeds the modem status from the modem control outputs instead of the pins.
    wire [3:0] msr_cur = loop ? {mcr_r[3], mcr_r[2], mcr_r[0], mcr_r[1]} : ~sync2_r[3:0];
    wire [3:0] char_bits = `UIS_CHAR_BASE + {2'b00, lcr_r[1:0]} + {3'b000, lcr_r[3]} + {3'b000, lcr_r[2]};
    wire [31:0] tmo_full = `UIS_TMO_CHARS * char_bits + `UIS_TMO_BITS;
    wire [6:0] tmo_limit = tmo_full[6:0];  // [RQ10]
    wire cts_rise = msr_prev_r[0] & ~msr_cur[0] & ~loop;
    wire rts_rise = rts_n_i & ~rts_prev_r;

    wire lsr_src = ier_eff[2] & lsr_pend_r;  // [RQ7]
    wire tmo_src = ier_eff[0] & timeout_r;
    wire rxr_src = ier_eff[0] & rx_cond;  // [RQ5]
    wire txr_src = ier_eff[1] & transmit_ready_irq_r;
    wire msr_src = ier_eff[3] & (|msr_delta_r);  // [RQ11]
    wire xch_src = ier_eff[5] & (xoff_pend_r | spec_pend_r);
    wire flc_src = flc_pend_r;

    reg [5:0] src_code;

    always @* begin
        // Only the highest-ranked source is reported; the rest wait their turn.
        if (lsr_src) src_code = `UIS_SRC_LSR;  // [RQ17] [RQ18]
        else if (tmo_src) src_code = `UIS_SRC_TMO;
        else if (rxr_src) src_code = `UIS_SRC_RXR;
        else if (txr_src) src_code = `UIS_SRC_TXR;
        else if (msr_src) src_code = `UIS_SRC_MSR;
        else if (xch_src) src_code = `UIS_SRC_XCH;
        else if (flc_src) src_code = `UIS_SRC_FLC;
        else src_code = `UIS_SRC_NONE;  // [RQ19]
    end

    wire pending = (src_code != `UIS_SRC_NONE);
    wire [7:0] isr_val = {fifo_enable_o, fifo_enable_o, src_code[5], src_code[4] | (enh & xoff_hold_r), src_code[3:0]};  // [RQ20] [RQ21]
    wire [7:0] lsr_val = {err_cnt_r != 5'h00, tx_empty_i, thr_empty_i, lsr_err_r, overrun_r, rx_any};  // [RQ2] [RQ3] [RQ4]
    wire [7:0] msr_val = {msr_cur, msr_delta_r};

    reg [7:0] rd_mux;

    always @* begin
        case (ra)
            `UIS_OFS_DATA: rd_mux = dlab ? (div_zero ? REV_CODE : dll_r) : rx_data_i;  // [RQ22]
            `UIS_OFS_IER: rd_mux = dlab ? (div_zero ? DEV_ID : dlm_r) : ier_eff;
            `UIS_OFS_ISR: rd_mux = bank_bf ? efr_r : isr_val;
            `UIS_OFS_LCR: rd_mux = lcr_r;
            `UIS_OFS_MCR: rd_mux = bank_bf ? resume_chars_o[7:0] : mcr_eff;
            `UIS_OFS_LSR: rd_mux = bank_bf ? resume_chars_o[15:8] : lsr_val;
            `UIS_OFS_MSR: rd_mux = bank_bf ? stop_chars_o[7:0] : msr_val;
            default: rd_mux = bank_bf ? stop_chars_o[15:8] : spr_r;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file and host-facing outputs.

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ier_r <= `UIS_RST_BYTE;
            lcr_r <= `UIS_RST_BYTE;
            mcr_r <= `UIS_RST_BYTE;
            efr_r <= `UIS_RST_BYTE;
            spr_r <= `UIS_RST_BYTE;
            dll_r <= `UIS_RST_BYTE;
            dlm_r <= `UIS_RST_BYTE;
            data_o <= `UIS_RST_BYTE;
            data_oe_o <= 1'b0;
            irq_o <= 1'b0;
            irq_oe_o <= 1'b0;
            rx_pop_o <= 1'b0;
            tx_push_o <= 1'b0;
            tx_data_o <= `UIS_RST_BYTE;
            divisor_o <= 16'h0000;
            line_control_o <= `UIS_RST_BYTE;
            modem_control_o <= `UIS_RST_BYTE;
            enhanced_o <= `UIS_RST_BYTE;
            fifo_enable_o <= 1'b0;
            rx_fifo_reset_o <= 1'b0;
            tx_fifo_reset_o <= 1'b0;
            rx_trigger_o <= 2'h0;
            tx_trigger_o <= 2'h0;
            resume_chars_o <= 16'h0000;
            stop_chars_o <= 16'h0000;
            sleep_enable_o <= 1'b0;
        end else begin
            rx_fifo_reset_o <= 1'b0;
            tx_fifo_reset_o <= 1'b0;
            data_oe_o <= rd_act;
            if (rd_go) data_o <= rd_mux;
            rx_pop_o <= rd_rhr;
            tx_push_o <= wr_thr;
            if (wr_thr) tx_data_o <= wd_r;
            if (wr_done) begin
                case (wa_r)
                    `UIS_OFS_DATA: if (dlab) dll_r <= wd_r;  // [RQ22]
                    `UIS_OFS_IER: begin
                        if (dlab) dlm_r <= wd_r;
                        else ier_r <= enh ? wd_r : {ier_r[7:4], wd_r[3:0]};  // [RQ8]
                    end
                    `UIS_OFS_ISR: begin
                        if (bank_bf) efr_r <= wd_r;
                        else begin
                            // Other control bits only take effect with the enable bit written as 1.
                            fifo_enable_o <= wd_r[0];
                            if (wd_r[0]) begin
                                rx_fifo_reset_o <= wd_r[1];
                                tx_fifo_reset_o <= wd_r[2];
                                rx_trigger_o <= wd_r[7:6];
                                if (enh) tx_trigger_o <= wd_r[5:4];  // [RQ8]
                            end
                        end
                    end
                    `UIS_OFS_LCR: lcr_r <= wd_r;
                    `UIS_OFS_MCR: begin
                        if (bank_bf) resume_chars_o[7:0] <= wd_r;
                        else mcr_r <= wd_r;
                    end
                    `UIS_OFS_LSR: if (bank_bf) resume_chars_o[15:8] <= wd_r;
                    `UIS_OFS_MSR: if (bank_bf) stop_chars_o[7:0] <= wd_r;
                    default: begin
                        if (bank_bf) stop_chars_o[15:8] <= wd_r;
                        else spr_r <= wd_r;
                    end
                endcase
            end
            divisor_o <= {dlm_r, dll_r};
            line_control_o <= lcr_r;
            modem_control_o <= mcr_eff;
            enhanced_o <= efr_r;
            sleep_enable_o <= ier_eff[4];
            irq_o <= pending;    // [RQ24]
            irq_oe_o <= mcr_r[3];  // [RQ23]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky interrupt state. A set in the same cycle as its clear wins, except in timeout_r and err_cnt_r, where the clear wins.

    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            lsr_pend_r <= 1'b0;
            overrun_r <= 1'b0;
            lsr_err_r <= 3'h0;
            head_new_r <= 1'b0;
            err_cnt_r <= 5'h00;
            tmo_cnt_r <= 7'h00;
            timeout_r <= 1'b0;
            transmit_ready_irq_r <= 1'b0;
            tx_cond_prev_r <= 1'b0;
            ier1_prev_r <= 1'b0;
            msr_prev_r <= 4'h0;
            msr_delta_r <= 4'h0;
            rts_prev_r <= 1'b0;
            flc_pend_r <= 1'b0;
            xoff_pend_r <= 1'b0;
            xoff_hold_r <= 1'b0;
            spec_pend_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            // A new byte reaches the read port after a pop or a push into an empty FIFO.
            head_new_r <= rx_pop_o | (rx_push_i & ~rx_any);
            if (rd_lsr) begin
                lsr_pend_r <= 1'b0;  // [RQ12]
                overrun_r <= 1'b0;
                lsr_err_r <= 3'h0;
            end
            if (overrun_i) begin
                overrun_r <= 1'b1;
                lsr_pend_r <= 1'b1;  // [RQ7]
            end
            if (head_new_r && rx_any) begin
                lsr_err_r <= rx_head_err_i;  // [RQ4]
                if (|rx_head_err_i) lsr_pend_r <= 1'b1;  // [RQ7]
            end
            // Global error counts errored bytes still inside the FIFO.
            if (rx_fifo_reset_o) err_cnt_r <= 5'h00;
            else if ((rx_push_i & rx_push_err_i) && !(rx_pop_o && rx_any && |rx_head_err_i))
                err_cnt_r <= err_cnt_r + 5'h01;
            else if (!(rx_push_i & rx_push_err_i) && rx_pop_o && rx_any && |rx_head_err_i && err_cnt_r != 5'h00)
                err_cnt_r <= err_cnt_r - 5'h01;  // [RQ12]
            // The idle timer restarts on any FIFO movement and only runs with data waiting.
            if (rx_push_i || rx_pop_o || !fifo_enable_o || !rx_any) tmo_cnt_r <= 7'h00;
            else if (bit_tick_i && tmo_cnt_r != tmo_limit) tmo_cnt_r <= tmo_cnt_r + 7'h01;
            if (rx_pop_o) timeout_r <= 1'b0;  // [RQ10]
            if (bit_tick_i && fifo_enable_o && rx_any && !rx_push_i && !rx_pop_o && tmo_cnt_r == tmo_limit - 7'h01)
                timeout_r <= 1'b1;  // [RQ10]
            tx_cond_prev_r <= tx_cond;
            ier1_prev_r <= ier_eff[1];
            if (wr_thr || (rd_isr && src_code == `UIS_SRC_TXR)) transmit_ready_irq_r <= 1'b0;  // [RQ14]
            if ((tx_cond && !tx_cond_prev_r) || (tx_cond && ier_eff[1] && !ier1_prev_r))
                transmit_ready_irq_r <= 1'b1;  // [RQ6]
            msr_prev_r <= msr_cur;
            if (rd_msr) begin
                msr_delta_r <= 4'h0;
                flc_pend_r <= 1'b0;  // [RQ16]
            end
            if (msr_cur[0] != msr_prev_r[0]) msr_delta_r[0] <= 1'b1;  // [RQ11]
            if (msr_cur[1] != msr_prev_r[1]) msr_delta_r[1] <= 1'b1;
            if (msr_prev_r[2] && !msr_cur[2]) msr_delta_r[2] <= 1'b1;
            if (msr_cur[3] != msr_prev_r[3]) msr_delta_r[3] <= 1'b1;
            rts_prev_r <= rts_n_i;
            if ((efr_r[7] & ier_eff[7] & cts_rise) | (efr_r[6] & ier_eff[6] & rts_rise))
                flc_pend_r <= 1'b1;  // [RQ9] [RQ20]
            if (rd_isr && src_code == `UIS_SRC_XCH) begin
                xoff_pend_r <= 1'b0;  // [RQ15]
                spec_pend_r <= 1'b0;
            end
            if (xon_det_i) begin
                xoff_pend_r <= 1'b0;  // [RQ15]
                xoff_hold_r <= 1'b0;  // [RQ20]
            end
            if (rx_push_i && !special_det_i) spec_pend_r <= 1'b0;
            if (xoff_det_i) begin
                xoff_pend_r <= 1'b1;
                xoff_hold_r <= 1'b1;
            end
            if (special_det_i) spec_pend_r <= 1'b1;
            if (rd_isr) wake_r <= 1'b0;  // [RQ16]
            if (wake_i && ier_eff[4]) wake_r <= 1'b1;
        end
    end

endmodule // uis_intr_status

// file: tb/uis_intr_status_chk_sva.sv
// Concurrent checks on the ports of the interrupt and status block.
module uis_intr_status_chk (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic rd_n_i,
    input wire logic [7:0] data_o,
    input wire logic data_oe_o,
    input wire logic irq_o,
    input wire logic irq_oe_o,
    input wire logic rx_pop_o,
    input wire logic tx_push_o,
    input wire logic [15:0] divisor_o,
    input wire logic [7:0] line_control_o,
    input wire logic [7:0] modem_control_o,
    input wire logic [7:0] enhanced_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////////////////
    chk_irq_oe_follow: assert property ($rose(modem_control_o[3]) |-> ##[0:2] irq_oe_o)
        else $error("interrupt pin not enabled after control bit set");
    chk_pop_single: assert property (rx_pop_o |=> !rx_pop_o)
        else $error("receive pop longer than one cycle");
    chk_pop_on_read: assert property (rx_pop_o |-> !$past(rd_n_i, 2) && !$past(cs_n_i, 2))
        else $error("receive pop without a host read");
    chk_push_single: assert property (tx_push_o |=> !tx_push_o)
        else $error("transmit push longer than one cycle");
    chk_oe_on_read: assert property ($rose(data_oe_o) |-> !$past(rd_n_i, 2) && !$past(cs_n_i, 2))
        else $error("data bus driven without a read");
    chk_data_hold: assert property (rd_n_i && $past(rd_n_i) && $past(rd_n_i, 2) |-> $stable(data_o))
        else $error("read data changed between reads");
    chk_divisor_dlab: assert property (!$stable(divisor_o) |-> line_control_o[7])
        else $error("divisor changed while latch access is off");
    chk_mcr_gated: assert property (!enhanced_o[4] && !$past(enhanced_o[4])
        |-> modem_control_o[7:5] == 3'b000 && !modem_control_o[2])
        else $error("gated modem control bits active");

    cover property (rx_pop_o);
    cover property (tx_push_o);
    cover property ($rose(irq_o));
endmodule // uis_intr_status_chk

bind uis_intr_status uis_intr_status_chk uis_intr_status_chk_inst (
    .clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .data_o(data_o),
    .data_oe_o(data_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o), .rx_pop_o(rx_pop_o),
    .tx_push_o(tx_push_o), .divisor_o(divisor_o), .line_control_o(line_control_o),
    .modem_control_o(modem_control_o), .enhanced_o(enhanced_o)
);

// file: tb/uis_host_model.sv
// Host processor model on the byte-wide strobe bus.
module uis_host_model (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_oe_i,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic [2:0] addr_o,
    output logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        addr_o = 3'h0;
        wdata_o = 8'hFF;
    end

    // Strobes hold beyond the three-cycle minimum.
    task write_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        #1;
        cs_n_o = 1'b0;
        wr_n_o = 1'b0;
        addr_o = a;
        wdata_o = d;
        repeat (4) @(posedge clock_i);
        #1;
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
        // A released bus must not keep showing the last byte.
        wdata_o = ~d;
        repeat (5) @(posedge clock_i);
    endtask

    task read_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock_i);
        #1;
        cs_n_o = 1'b0;
        rd_n_o = 1'b0;
        addr_o = a;
        repeat (5) @(posedge clock_i);
        d = (rdata_oe_i === 1'b1) ? rdata_i : 8'hXX;
        #1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        repeat (5) @(posedge clock_i);
    endtask
endmodule // uis_host_model

// file: tb/uis_intr_status_bench.sv
// Self-checking bench for the interrupt and status block.
module uis_intr_status_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_i = 1'b0, reset_i = 1'b1, cs_n, rd_n, wr_n, data_oe_o, irq_o, irq_oe_o, rx_pop_o, tx_push_o;
    logic [2:0] addr;
    logic [7:0] data_i, data_o, tx_data_o, line_control_o, modem_control_o, enhanced_o, v;
    logic cts_n_i = 1'b1, dsr_n_i = 1'b1, cd_n_i = 1'b1, ri_n_i = 1'b1, rts_n_i = 1'b0;
    logic rx_push_i = 1'b0, overrun_i = 1'b0, thr_empty_i = 1'b1, tx_empty_i = 1'b1;
    logic xoff_det_i = 1'b0, xon_det_i = 1'b0, bit_tick_i = 1'b0, special_det_i = 1'b0, fifo_enable_o;
    logic [4:0] rx_level_i = 5'h00;
    logic [15:0] divisor_o;
    logic [1:0] rx_trigger_o;
    int mismatches = 0, total_checks = 0;

    always #5 clock_i = ~clock_i;

    uis_host_model uis_host_model_inst (.clock_i(clock_i), .rdata_i(data_o), .rdata_oe_i(data_oe_o),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(data_i));

    uis_intr_status uis_intr_status_inst (.clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n),
        .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(data_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o), .cts_n_i(cts_n_i),
        .dsr_n_i(dsr_n_i), .cd_n_i(cd_n_i), .ri_n_i(ri_n_i), .rts_n_i(rts_n_i), .rx_data_i(8'h7E),
        .rx_level_i(rx_level_i), .rx_push_i(rx_push_i), .rx_push_err_i(1'b0), .rx_head_err_i(3'h0),
        .overrun_i(overrun_i), .thr_empty_i(thr_empty_i), .tx_empty_i(tx_empty_i),
        .tx_level_i(5'h00), .bit_tick_i(bit_tick_i), .xoff_det_i(xoff_det_i), .xon_det_i(xon_det_i),
        .special_det_i(special_det_i), .wake_i(1'b0), .rx_pop_o(rx_pop_o), .tx_push_o(tx_push_o),
        .tx_data_o(tx_data_o), .divisor_o(divisor_o), .line_control_o(line_control_o),
        .modem_control_o(modem_control_o), .enhanced_o(enhanced_o), .fifo_enable_o(fifo_enable_o),
        .rx_fifo_reset_o(), .tx_fifo_reset_o(), .rx_trigger_o(rx_trigger_o), .tx_trigger_o(),
        .resume_chars_o(), .stop_chars_o(), .sleep_enable_o());

    // Receive FIFO and transmitter stand-ins: a pop drains one byte, a push fills the holding register.
    always @(posedge clock_i) begin
        if (rx_pop_o) rx_level_i <= rx_level_i - 5'h01;
        if (tx_push_o) begin
            thr_empty_i <= 1'b0;
            tx_empty_i <= 1'b0;
        end
    end

    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task rchk(input logic [2:0] a, input logic [7:0] exp, input string what);
        uis_host_model_inst.read_reg(a, v);
        check({8'h00, v}, {8'h00, exp}, what);
    endtask

    task wr(input logic [2:0] a, input logic [7:0] d);
        uis_host_model_inst.write_reg(a, d);
    endtask

    task automatic pulse(ref logic s);
        @(posedge clock_i);
        #1 s = 1'b1;
        @(posedge clock_i);
        #1 s = 1'b0;
        repeat (4) @(posedge clock_i);
    endtask

    task push_byte;
        @(posedge clock_i);
        #1 rx_level_i = rx_level_i + 5'h01;
        rx_push_i = 1'b1;
        @(posedge clock_i);
        #1 rx_push_i = 1'b0;
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clock_i);
        mismatches++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge clock_i);
        #1 reset_i = 1'b0;
        rchk(3'h2, 8'h01, "status after reset");
        wr(3'h3, 8'h80);
        rchk(3'h0, 8'h2A, "revision code");
        rchk(3'h1, 8'h5C, "device id");
        wr(3'h0, 8'h34);
        wr(3'h1, 8'h12);
        check(divisor_o, 16'h1234, "divisor");
        rchk(3'h0, 8'h34, "divisor low");
        wr(3'h3, 8'h03);
        wr(3'h7, 8'hA5);
        rchk(3'h7, 8'hA5, "scratchpad");
        $display("test registers done");
        wr(3'h4, 8'h08);
        check({15'h0, irq_oe_o}, 16'h0001, "irq enable");
        wr(3'h1, 8'hF2);
        rchk(3'h1, 8'h02, "gated enables");
        check({15'h0, irq_o}, 16'h0001, "irq on tx ready");
        rchk(3'h2, 8'h02, "tx ready code");
        rchk(3'h2, 8'h01, "tx ready read");
        check({15'h0, irq_o}, 16'h0000, "irq idle");
        wr(3'h0, 8'h5A);
        check({8'h00, tx_data_o}, 16'h005A, "sent byte");
        #1 {thr_empty_i, tx_empty_i} = 2'b11;
        wr(3'h0, 8'hC3);
        rchk(3'h2, 8'h01, "tx ready write");
        #1 {thr_empty_i, tx_empty_i} = 2'b11;
        $display("test transmit done");
        wr(3'h1, 8'h08);
        #1 {cts_n_i, dsr_n_i, cd_n_i, ri_n_i} = 4'h0;
        repeat (6) @(posedge clock_i);
        rchk(3'h2, 8'h00, "modem code");
        uis_host_model_inst.read_reg(3'h6, v);
        check({8'h00, v & 8'hF1}, 16'h00F1, "modem status");
        rchk(3'h2, 8'h01, "modem cleared");
        $display("test modem done");
        wr(3'h2, 8'h41);
        check({13'h0, fifo_enable_o, rx_trigger_o}, 16'h0005, "fifo setup");
        wr(3'h1, 8'h05);
        rchk(3'h5, 8'h60, "status empty");
        push_byte();
        rchk(3'h5, 8'h61, "data ready");
        push_byte();
        push_byte();
        rchk(3'h2, 8'hC1, "below trigger");
        push_byte();
        rchk(3'h2, 8'hC4, "trigger reached");
        pulse(overrun_i);
        rchk(3'h2, 8'hC6, "overrun first");
        rchk(3'h5, 8'h63, "overrun flag");
        rchk(3'h2, 8'hC4, "rx ready queued");
        rchk(3'h0, 8'h7E, "rx byte");
        rchk(3'h2, 8'hC1, "rx ready cleared");
        #1 bit_tick_i = 1'b1;
        repeat (60) @(posedge clock_i);
        rchk(3'h2, 8'hCC, "time-out");
        for (int i = 0; i < 3; i++) rchk(3'h0, 8'h7E, "drain");
        rchk(3'h5, 8'h60, "data ready off");
        $display("test receive done");
        wr(3'h3, 8'hBF);
        wr(3'h2, 8'hD0);
        wr(3'h3, 8'h03);
        wr(3'h1, 8'hE0);
        check({8'h00, enhanced_o}, 16'h00D0, "enhanced");
        #1 cts_n_i = 1'b1;
        repeat (6) @(posedge clock_i);
        rchk(3'h2, 8'hE0, "cts change");
        uis_host_model_inst.read_reg(3'h6, v);
        rchk(3'h2, 8'hC1, "cts cleared");
        #1 rts_n_i = 1'b1;
        repeat (6) @(posedge clock_i);
        rchk(3'h2, 8'hE0, "rts change");
        uis_host_model_inst.read_reg(3'h6, v);
        rchk(3'h2, 8'hC1, "rts cleared");
        pulse(xoff_det_i);
        rchk(3'h2, 8'hD0, "stop char");
        rchk(3'h2, 8'hD1, "stop held");
        pulse(xon_det_i);
        rchk(3'h2, 8'hC1, "resume");
        pulse(special_det_i);
        rchk(3'h2, 8'hD0, "special char");
        $display("test enhanced done");
        summarize();
    end
endmodule // uis_intr_status_bench
